// ---- rtl/acs_device.sv ----
/*
 Calibration sequencer, converter end. Runs the mode-field sequences,
 times them in output-rate periods, clears the field on completion and
 drives the active-low data-ready flag and the data word.
 Assumes the host keeps its calibration inputs steady during a step.
*/
// Contract
// R1: Mode 010 starts zero-scale system calibration
// R2: System step lasts three periods, then mode clears
// R3: Data-ready high from start until new word
// R4: System step: flag falls after four periods
// R5: Following conversion samples the calibration input
// R6: Flag may rise up to one modulator cycle late
// R7: Host ignores flag one modulator cycle
// R8: Mode 011 starts full-scale system calibration
// R9: Host orders zero before full, holds inputs
// R10: Unipolar endpoints, bipolar midscale to full scale
// R11: Single-step calibration keeps other coefficient
// R12: Host needs valid zero before full-scale
// R13: Mode 100 starts system-offset calibration
// R14: System-offset runs six periods, then mode clears
// R15: System-offset flag falls after nine periods
// R16: Mode 101 enters zero-scale-only background mode
// R17: Background recalibrates each update, rate over six
// R18: Background mode persists until host rewrites
// R19: Host self-calibrates before background mode (host accepts it after any zero-scale step, system modes 010/100 included)
// R20: Host avoids filter sync in background mode
// R21: Full-scale system step uses selected gain
// R22: Mode 001 runs full self-calibration
// R23: Modes 110/111 run zero/full self-calibration
// R24: Mode 000 is normal conversion
`timescale 1ns/1ps
module acs_device (
  // Link to host
  acs_if.device     link,
  // User side: converter setup and coefficients
  input  wire logic bipolar,
  output logic [23:0] zs_coef,
  output logic [23:0] fs_coef,
  output logic      cal_busy
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  acs_pkg::acs_phase_e phase_ff, nxt_phase;
  logic [2:0]  mode_ff;
  logic [3:0]  per_ff;
  logic        fs_pend_ff;
  logic        conv_self_ff;
  logic        rdy_n_ff;
  logic [23:0] word_ff;
  logic [23:0] zs_ff, fs_ff;
  logic        mod_tick, rate_tick;

  wire clk  = link.clk;
  wire rstn = link.rstn;
  wire start = link.mode_wr & (link.mode_wdata != acs_pkg::MODE_NORMAL); // [R24]
  wire abort = link.mode_wr & (link.mode_wdata == acs_pkg::MODE_NORMAL);
  // Rate counting restarts at the command so periods line up with it
  wire clear = link.mode_wr;

  acs_rate_div u_div (
    .clk       (clk),
    .rstn      (rstn),
    .clear     (clear),
    .mod_tick  (mod_tick),
    .rate_tick (rate_tick)
  );

  // ---------------------------------------------------------------
  // Endpoint selection
  // ---------------------------------------------------------------
  // Input code 0 zero point (midscale when bipolar), 1 full-scale point, 2/3 read as the zero word
  function automatic logic [23:0] sample(input logic [1:0] sel, input logic bip);
    logic [23:0] w;
    w = (sel == 2'h1) ? acs_pkg::FULL_WORD : acs_pkg::ZERO_WORD;
    if (bip && sel == 2'h0)
      w = acs_pkg::MID_WORD; // [R10]
    return w;
  endfunction

  wire [23:0] ain_word  = sample(link.analog_input, bipolar); // [R5] [R21]
  wire        per_done  = rate_tick & (per_ff == acs_pkg::STEP_PERIODS - 4'h1);
  wire        conv_done = rate_tick & (per_ff == (conv_self_ff ? acs_pkg::SELF_CONV_PER
                                                 : acs_pkg::SYS_CONV_PER) - 4'h1);
  wire        bg_done   = rate_tick & (per_ff == acs_pkg::BG_CAL_PERIODS - 4'h1);
  wire        zs_take   = (phase_ff == acs_pkg::PH_ZS) & per_done;
  wire        fs_take   = (phase_ff == acs_pkg::PH_FS) & per_done;

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      acs_pkg::PH_IDLE:    nxt_phase = acs_pkg::PH_IDLE;
      acs_pkg::PH_ZS:      if (per_done) nxt_phase = fs_pend_ff ? acs_pkg::PH_FS
                                                                : acs_pkg::PH_CONV;
      acs_pkg::PH_FS:      if (per_done) nxt_phase = acs_pkg::PH_CONV;
      acs_pkg::PH_CONV:    if (conv_done) nxt_phase = acs_pkg::PH_IDLE;
      acs_pkg::PH_BG_CONV: if (rate_tick) nxt_phase = acs_pkg::PH_BG_ZS; // [R17]
      acs_pkg::PH_BG_ZS:   if (bg_done) nxt_phase = acs_pkg::PH_BG_CONV;
      default:             nxt_phase = acs_pkg::PH_IDLE;
    endcase
    if (abort)
      nxt_phase = acs_pkg::PH_IDLE;
    else if (start)
      case (link.mode_wdata)
        acs_pkg::MODE_SYS_FS,
        acs_pkg::MODE_SELF_FS: nxt_phase = acs_pkg::PH_FS;                // [R8] [R23]
        acs_pkg::MODE_BACKGND: nxt_phase = acs_pkg::PH_BG_CONV;          // [R16]
        default:               nxt_phase = acs_pkg::PH_ZS;               // [R1] [R13] [R22]
      endcase
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      phase_ff <= acs_pkg::PH_IDLE;
    else
      phase_ff <= nxt_phase;

  // Period counter restarts on each phase change
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      per_ff <= 4'h0;
    else if (nxt_phase != phase_ff || clear)
      per_ff <= 4'h0;
    else if (rate_tick)
      per_ff <= per_ff + 4'h1;

  // Remember whether a full-scale step follows zero-scale
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      fs_pend_ff   <= 1'b0;
      conv_self_ff <= 1'b0;
    end
    else if (start)
    begin
      fs_pend_ff   <= (link.mode_wdata == acs_pkg::MODE_SELF) ||
                      (link.mode_wdata == acs_pkg::MODE_SYS_OFS); // [R14]
      conv_self_ff <= (link.mode_wdata == acs_pkg::MODE_SELF) ||
                      (link.mode_wdata == acs_pkg::MODE_SYS_OFS) ||
                      (link.mode_wdata == acs_pkg::MODE_SELF_ZS) ||
                      (link.mode_wdata == acs_pkg::MODE_SELF_FS); // [R15]
    end

  // ---------------------------------------------------------------
  // Mode field: cleared by hardware when the calibration steps end
  // ---------------------------------------------------------------
  wire cal_end = (phase_ff == acs_pkg::PH_ZS && per_done && !fs_pend_ff) ||
                 (phase_ff == acs_pkg::PH_FS && per_done);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      mode_ff <= acs_pkg::MODE_NORMAL;
    else if (link.mode_wr)
      mode_ff <= link.mode_wdata;            // Host write wins; new command
    else if (cal_end && mode_ff != acs_pkg::MODE_BACKGND)
      mode_ff <= acs_pkg::MODE_NORMAL;       // [R2] [R14] [R18]

  // ---------------------------------------------------------------
  // Coefficients: each step writes only its own
  // ---------------------------------------------------------------
  wire internal_zs = (mode_ff == acs_pkg::MODE_SELF) || (mode_ff == acs_pkg::MODE_SELF_ZS) ||
                     (phase_ff == acs_pkg::PH_BG_ZS);                      // [R23]
  wire internal_fs = (mode_ff != acs_pkg::MODE_SYS_FS);                   // [R14]
  wire bg_zs_take  = (phase_ff == acs_pkg::PH_BG_ZS) & bg_done;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      zs_ff <= acs_pkg::ZERO_WORD;
      fs_ff <= acs_pkg::FULL_WORD;
    end
    else
    begin
      if (zs_take || bg_zs_take)
        zs_ff <= internal_zs ? acs_pkg::ZERO_WORD : ain_word;             // [R11] [R17]
      if (fs_take)
        fs_ff <= internal_fs ? acs_pkg::FULL_WORD : ain_word;             // [R11] [R21]
    end

  // ---------------------------------------------------------------
  // Data-ready and data word
  // ---------------------------------------------------------------
  // Raised on the clock after the command write, so well within one modulator cycle
  wire word_ready = ((phase_ff == acs_pkg::PH_CONV) & conv_done) ||
                    ((phase_ff == acs_pkg::PH_BG_CONV) & rate_tick);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rdy_n_ff <= 1'b1;
    else if (word_ready)
      rdy_n_ff <= 1'b0;                                                    // [R4] [R15]
    else if (start || (phase_ff != acs_pkg::PH_IDLE && phase_ff != acs_pkg::PH_BG_CONV))
      rdy_n_ff <= 1'b1;                                                    // [R3] [R6]

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      word_ff <= acs_pkg::ZERO_WORD;
    else if (word_ready)
      word_ff <= ain_word;                                                 // [R5]

  assign link.mode_rdata   = mode_ff;
  assign link.data_ready_n = rdy_n_ff;
  assign link.data_word    = word_ff;
  assign zs_coef           = zs_ff;
  assign fs_coef           = fs_ff;
  assign cal_busy          = (phase_ff != acs_pkg::PH_IDLE) &&
                             (phase_ff != acs_pkg::PH_BG_CONV);
endmodule // acs_device

// ---- rtl/acs_host.sv ----
/*
 Host end: issues calibration commands on request, refuses full-scale
 and background commands until a zero-scale step has been requested,
 and masks the data-ready flag for one modulator cycle after each command.
 Assumes the user presents the calibration input before requesting.
*/
`timescale 1ns/1ps
module acs_host (
  // Link to device
  acs_if.host       link,
  // User side
  input  wire logic       cmd_req,
  input  wire logic [2:0] cmd_mode,
  input  wire logic [1:0] cmd_input,
  input  wire logic       sync_req,
  output logic            cmd_ack,
  output logic            word_valid,
  output logic [23:0]     word_out,
  output logic            zs_valid
);
  logic       wr_ff;
  logic [2:0] wdata_ff;
  logic [1:0] ain_ff;
  logic [7:0] mask_ff;
  logic       zs_ok_ff;
  logic       bg_ff;
  logic       rdy_d_ff;
  logic [23:0] word_ff;
  logic       valid_ff;

  wire clk  = link.clk;
  wire rstn = link.rstn;
  // Full-scale only after a zero-scale reference exists
  wire is_fs = (cmd_mode == acs_pkg::MODE_SYS_FS) || (cmd_mode == acs_pkg::MODE_SELF_FS);
  // Normal mode writes no coefficient, so it never counts as a zero-scale step
  wire zs_cap = (cmd_mode == acs_pkg::MODE_SELF) || (cmd_mode == acs_pkg::MODE_SYS_ZS) ||
                (cmd_mode == acs_pkg::MODE_SYS_OFS) || (cmd_mode == acs_pkg::MODE_SELF_ZS);
  wire bg_sel = (cmd_mode == acs_pkg::MODE_BACKGND);
  // Background refused too: it needs a zero-scale reference, like full-scale
  wire accept = cmd_req & ~((is_fs | bg_sel) & ~zs_ok_ff);               // [R9] [R12] [R19]
  wire masked = (mask_ff != 8'h00);
  wire rdy_fall = ~masked & rdy_d_ff & ~link.data_ready_n;

  assign cmd_ack = accept;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      wr_ff    <= 1'b0;
      wdata_ff <= acs_pkg::MODE_NORMAL;
      ain_ff   <= 2'h0;
    end
    else
    begin
      wr_ff <= accept;
      if (accept)
      begin
        wdata_ff <= cmd_mode;
        ain_ff   <= cmd_input;
      end
    end

  // Mask spans one modulator cycle after the command write
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      mask_ff <= 8'h00;
    else if (wr_ff)
      mask_ff <= 8'(acs_pkg::MOD_DIV);                                    // [R7]
    else if (masked)
      mask_ff <= mask_ff - 8'h01;

  // Zero-scale valid once a zero-capable mode is accepted; background needs it too
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      zs_ok_ff <= 1'b0;
      bg_ff    <= 1'b0;
    end
    else if (accept)
    begin
      zs_ok_ff <= zs_ok_ff | zs_cap;
      bg_ff    <= bg_sel;                                                  // [R19]
    end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rdy_d_ff <= 1'b1;
      word_ff  <= acs_pkg::ZERO_WORD;
      valid_ff <= 1'b0;
    end
    else
    begin
      rdy_d_ff <= link.data_ready_n;
      valid_ff <= rdy_fall;
      if (rdy_fall)
        word_ff <= link.data_word;
    end

  assign link.mode_wr         = wr_ff;
  assign link.mode_wdata      = wdata_ff;
  assign link.analog_input    = ain_ff;
  assign link.filter_sync_bit = sync_req & ~bg_ff;                         // [R20]
  assign word_valid           = valid_ff;
  assign word_out             = word_ff;
  assign zs_valid             = zs_ok_ff;
endmodule // acs_host

// ---- rtl/acs_if.sv ----
/*
 Link between the host and the calibration sequencer: mode field write
 port, mode readback, active-low data-ready flag, data word and the
 analog input selector the host presents.
 Assumes both ends share clk and rstn.
*/
`timescale 1ns/1ps
interface acs_if (
  input wire logic clk,
  input wire logic rstn
);
  logic        mode_wr;
  logic [2:0]  mode_wdata;
  logic [2:0]  mode_rdata;
  logic        data_ready_n;
  logic [23:0] data_word;
  logic [1:0]  analog_input;
  logic        filter_sync_bit;

  modport device (
    input  clk, rstn, mode_wr, mode_wdata, analog_input, filter_sync_bit,
    output mode_rdata, data_ready_n, data_word
  );
  modport host (
    input  clk, rstn, mode_rdata, data_ready_n, data_word,
    output mode_wr, mode_wdata, analog_input, filter_sync_bit
  );
endinterface

// ---- rtl/acs_pkg.sv ----
/*
 Shared constants for the calibration sequencer: mode codes, timing
 figures used by both ends, and the device phase encoding.
 Assumes a single 200 MHz clock and an active-low asynchronous reset.
*/
package acs_pkg;

  // ---------------------------------------------------------------
  // Mode field codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_SELF     = 3'h1;
  localparam logic [2:0] MODE_SYS_ZS   = 3'h2;
  localparam logic [2:0] MODE_SYS_FS   = 3'h3;
  localparam logic [2:0] MODE_SYS_OFS  = 3'h4;
  localparam logic [2:0] MODE_BACKGND  = 3'h5;
  localparam logic [2:0] MODE_SELF_ZS  = 3'h6;
  localparam logic [2:0] MODE_SELF_FS  = 3'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          MOD_DIV         = 128;
  localparam logic [6:0]  MOD_DIV_LAST    = 7'(MOD_DIV - 1);
  // Output-rate period counted in modulator cycles
  localparam int          RATE_DIV        = 16;
  localparam logic [3:0]  RATE_DIV_LAST   = 4'(RATE_DIV - 1);
  localparam logic [3:0]  STEP_PERIODS    = 4'h3;
  localparam logic [3:0]  SYS_CONV_PER    = 4'h1;
  localparam logic [3:0]  SELF_CONV_PER   = 4'h3;
  localparam logic [3:0]  BG_DIVIDE       = 4'h6;
  localparam logic [3:0]  BG_CAL_PERIODS  = 4'(BG_DIVIDE - 1);

  // ---------------------------------------------------------------
  // Sequencer phases
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ZS,
    PH_FS,
    PH_CONV,
    PH_BG_CONV,
    PH_BG_ZS
  } acs_phase_e;

  localparam logic [23:0] ZERO_WORD = 24'h000000;
  localparam logic [23:0] FULL_WORD = 24'hffffff;
  localparam logic [23:0] MID_WORD  = 24'h800000;

endpackage

// ---- rtl/acs_rate_div.sv ----
/*
 Divider giving the modulator-cycle and output-rate enables.
 Assumes clk at 200 MHz; clear restarts both counts.
*/
`timescale 1ns/1ps
module acs_rate_div (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic clear,
  // Enables
  output logic      mod_tick,
  output logic      rate_tick
);
  logic [6:0] mod_cnt_ff;
  logic [3:0] rate_cnt_ff;
  wire        mod_wrap  = (mod_cnt_ff == acs_pkg::MOD_DIV_LAST);
  wire        rate_wrap = (rate_cnt_ff == acs_pkg::RATE_DIV_LAST);

  assign mod_tick  = mod_wrap & ~clear;
  assign rate_tick = mod_tick & rate_wrap;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      mod_cnt_ff <= 7'h00;
    else if (clear || mod_wrap)
      mod_cnt_ff <= 7'h00;
    else
      mod_cnt_ff <= mod_cnt_ff + 7'h01;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rate_cnt_ff <= 4'h0;
    else if (clear || rate_tick)
      rate_cnt_ff <= 4'h0;
    else if (mod_tick)
      rate_cnt_ff <= rate_cnt_ff + 4'h1;
endmodule // acs_rate_div

// ---- sim/acs_monitor.sv ----
/*
 Checker for the host/device link of the calibration sequencer.
 Assumes it watches the link interface signals of one clk domain.
*/
`timescale 1ns/1ps
module acs_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Link
  input wire logic        mode_wr,
  input wire logic [2:0]  mode_wdata,
  input wire logic [2:0]  mode_rdata,
  input wire logic        data_ready_n,
  input wire logic [23:0] data_word,
  input wire logic [1:0]  analog_input,
  input wire logic        filter_sync_bit
);
  localparam int P = acs_pkg::MOD_DIV * acs_pkg::RATE_DIV;
  // ---------------------------------------------------------------
  // Time since last write, latched command
  // ---------------------------------------------------------------
  logic [15:0] cnt_ff;
  logic [2:0]  cur_ff;
  logic        seen_zs_ff;
  wire         step6   = cur_ff == acs_pkg::MODE_SELF || cur_ff == acs_pkg::MODE_SYS_OFS;
  wire         step3   = cur_ff[1];
  wire         timed   = step3 || step6;
  wire [15:0]  done_at = step6 ? 16'(6 * P) : 16'(3 * P);
  wire [15:0]  flag_at = step6 ? 16'(9 * P) : (cur_ff[2] ? 16'(6 * P) : 16'(4 * P));
  wire         zs_cmd  = mode_wdata inside {3'h1, 3'h2, 3'h4, 3'h6};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff     <= 16'h0000;
      cur_ff     <= 3'h0;
      seen_zs_ff <= 1'b0;
    end
    else
    begin
      cnt_ff     <= mode_wr ? 16'h0001 : cnt_ff + 16'(cnt_ff != 16'hffff);
      cur_ff     <= mode_wr ? mode_wdata : cur_ff;
      seen_zs_ff <= seen_zs_ff | (mode_wr & zs_cmd);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  mode_echo_a: assert property (mode_wr |=> mode_rdata == $past(mode_wdata))
    else $error("mode field does not show the written code");
  flag_rise_a: assert property (mode_wr && mode_wdata != 3'h0
    |-> ##[1:128] data_ready_n)
    else $error("ready flag not raised after calibration start");
  mode_hold_a: assert property (timed && cnt_ff >= 2 && cnt_ff <= done_at - 4
    |-> mode_rdata == cur_ff)
    else $error("mode field cleared too early");
  mode_clear_a: assert property (timed && cnt_ff >= done_at + 4
    |-> mode_rdata == 3'h0)
    else $error("mode field not cleared after the step");
  flag_busy_a: assert property (timed && cnt_ff >= 130 && cnt_ff <= flag_at - 4
    |-> data_ready_n)
    else $error("ready flag low during calibration");
  // Looked at just after the fall: the next command follows within a few cycles
  flag_fall_a: assert property (timed && cnt_ff == flag_at + 2 |-> !data_ready_n)
    else $error("ready flag late after calibration");
  bg_stay_a: assert property (cur_ff == acs_pkg::MODE_BACKGND && cnt_ff >= 2
    |-> mode_rdata == acs_pkg::MODE_BACKGND)
    else $error("background mode left on its own");
  sync_gate_a: assert property (mode_rdata == acs_pkg::MODE_BACKGND && cnt_ff >= 2
    |-> !filter_sync_bit)
    else $error("filter sync used in background mode");
  fs_word_a: assert property ($fell(data_ready_n) && cur_ff == acs_pkg::MODE_SYS_FS
    |-> data_word == acs_pkg::FULL_WORD)
    else $error("full-scale step word is not full scale");
  fs_order_a: assert property (mode_wr && mode_wdata inside {3'h3, 3'h7} |-> seen_zs_ff)
    else $error("full-scale command before zero-scale");
endmodule // acs_monitor

// ---- sim/test_adc_calibration_sequencer.sv ----
/*
 Self-checking bench: host and device joined by the link interface.
 Assumes the package constants and one 200 MHz clock.
*/
`timescale 1ns/1ps
module test_adc_calibration_sequencer;
  localparam int P = acs_pkg::MOD_DIV * acs_pkg::RATE_DIV;
  typedef struct {
    logic [2:0]  mode;
    logic [1:0]  inp;
    logic        bip;
    logic [23:0] word;
    int          per;
  } acs_row_s;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        bipolar = 1'b0;
  logic        cmd_req = 1'b0;
  logic [2:0]  cmd_mode = 3'h0;
  logic [1:0]  cmd_input = 2'h0;
  logic        sync_req = 1'b0;
  logic        cmd_ack;
  logic        word_valid;
  logic [23:0] word_out;
  logic [23:0] zs_coef;
  logic [23:0] fs_coef;
  logic [23:0] fs_keep;
  logic        cal_busy;
  logic        zs_valid;
  logic        ok;
  int          n;
  int          errors = 0;
  int          num_checks = 0;
  // Zero-scale step first: host refuses full-scale before it
  acs_row_s rows [6] = '{
    '{acs_pkg::MODE_SYS_ZS,  2'h0, 1'b1, acs_pkg::MID_WORD,  4},
    '{acs_pkg::MODE_SYS_FS,  2'h1, 1'b0, acs_pkg::FULL_WORD, 4},
    '{acs_pkg::MODE_SYS_OFS, 2'h0, 1'b0, acs_pkg::ZERO_WORD, 9},
    '{acs_pkg::MODE_SELF,    2'h0, 1'b0, acs_pkg::ZERO_WORD, 9},
    '{acs_pkg::MODE_SELF_ZS, 2'h0, 1'b0, acs_pkg::ZERO_WORD, 6},
    '{acs_pkg::MODE_SELF_FS, 2'h1, 1'b0, acs_pkg::FULL_WORD, 6}
  };

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  acs_if acs_if_i (.clk(clk), .rstn(rstn));
  acs_device acs_device_i (.link(acs_if_i.device), .bipolar(bipolar), .zs_coef(zs_coef),
    .fs_coef(fs_coef), .cal_busy(cal_busy));
  acs_host acs_host_i (.link(acs_if_i.host), .cmd_req(cmd_req), .cmd_mode(cmd_mode),
    .cmd_input(cmd_input), .sync_req(sync_req), .cmd_ack(cmd_ack),
    .word_valid(word_valid), .word_out(word_out), .zs_valid(zs_valid));
  acs_monitor acs_monitor_i (.clk(clk), .rstn(rstn), .mode_wr(acs_if_i.mode_wr),
    .mode_wdata(acs_if_i.mode_wdata), .mode_rdata(acs_if_i.mode_rdata),
    .data_ready_n(acs_if_i.data_ready_n), .data_word(acs_if_i.data_word),
    .analog_input(acs_if_i.analog_input), .filter_sync_bit(acs_if_i.filter_sync_bit));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Input is set one cycle ahead and held through the step
  task automatic send(input logic [2:0] m, input logic [1:0] a, output logic acc);
    @(posedge clk);
    cmd_input <= a;
    @(posedge clk);
    cmd_req  <= 1'b1;
    cmd_mode <= m;
    #1 acc = cmd_ack;
    @(posedge clk);
    cmd_req <= 1'b0;
  endtask

  task automatic wait_word(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      #1 cyc++;
    end while (word_valid !== 1'b1 && cyc < 40000);
    if (cyc >= 40000)
      errors++;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk);
      bipolar <= rows[i].bip;
      #1 fs_keep = fs_coef;
      send(rows[i].mode, rows[i].inp, ok);
      check(24'(ok), 24'h000001);
      wait_word(n);
      check(word_out, rows[i].word);
      check(24'(acs_if_i.mode_rdata), 24'h000000);
      check(24'(n >= rows[i].per * P && n <= rows[i].per * P + 12), 24'h000001);
      if (rows[i].mode == acs_pkg::MODE_SELF_ZS)
        check(fs_coef, fs_keep);
    end
    // Background: zero-scale only, slower output, sticky mode
    sync_req <= 1'b1;
    send(acs_pkg::MODE_BACKGND, 2'h2, ok);
    check(24'(ok), 24'h000001);
    wait_word(n);
    wait_word(n);
    check(24'(n >= 6 * P - 4 && n <= 6 * P + 4), 24'h000001);
    check(24'(acs_if_i.mode_rdata), 24'(acs_pkg::MODE_BACKGND));
    check(24'(acs_if_i.filter_sync_bit), 24'h000000);
    check(24'(zs_valid), 24'h000001);
    sync_req <= 1'b0;
    // Abort a running step by writing normal mode
    send(acs_pkg::MODE_SYS_ZS, 2'h0, ok);
    repeat (100) @(posedge clk);
    #1 check(24'(cal_busy), 24'h000001);
    send(acs_pkg::MODE_NORMAL, 2'h0, ok);
    repeat (3) @(posedge clk);
    #1 check(24'(acs_if_i.mode_rdata), 24'h000000);
    check(24'(cal_busy), 24'h000000);
    // Mid-run reset, then a full-scale command with no zero-scale
    @(posedge clk);
    rstn     <= 1'b0;
    sync_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(24'(acs_if_i.data_ready_n), 24'h000001);
    check(24'(acs_if_i.filter_sync_bit), 24'h000001);
    check(fs_coef, acs_pkg::FULL_WORD);
    check(zs_coef, acs_pkg::ZERO_WORD);
    check(24'(zs_valid), 24'h000000);
    @(posedge clk);
    rstn     <= 1'b1;
    sync_req <= 1'b0;
    // Background and full-scale both wait for a zero-scale step; normal does not count
    send(acs_pkg::MODE_BACKGND, 2'h0, ok);
    check(24'(ok), 24'h000000);
    send(acs_pkg::MODE_NORMAL, 2'h0, ok);
    check(24'(ok), 24'h000001);
    send(acs_pkg::MODE_SYS_FS, 2'h1, ok);
    check(24'(ok), 24'h000000);
    repeat (4) @(posedge clk);
    #1 check(24'(acs_if_i.mode_rdata), 24'h000000);
    stop_test();
  end

  // Tests take about 92.5k cycles; stop before 100k
  initial
  begin
    #(98000 * 5);
    errors++;
    stop_test();
  end
endmodule // test_adc_calibration_sequencer
